// ---- hdl/klsor_regs.sv ----
// key lock, tick control and signal override register block
`timescale 1ns/1ps
// What this block does
// - writes to protected registers land only while the key holds 0x0013.
// - the key register is 16 bits, resets to zero and is cleared by clear.
// - the tick control register, trim field included, is key protected.
// - reading a comparator force bit returns that comparator's raw value.
// - with the global analog force set, force bits feed the debounce inputs.
// - bit 9 of the force register pins the lock indication to locked.
// - bit 8 of the force register swaps every debounce tick for 16 kHz.
// - bit 6 of the force register holds the alarm asserted.
// - raw regulator state reads at bits 15, 11:8, 3:0 and clear zeroes it.
module klsor_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sm_clear,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  input wire logic analog_force_enable,
  input wire logic [15:0] cmp_raw,
  input wire logic [15:0] reg_raw_state,
  input wire logic lock_raw,
  input wire logic alarm_raw,
  input wire logic deb_tick_normal,
  output logic [15:0] deb_in_q,
  output logic lock_ok_q,
  output logic alarm_q,
  output logic deb_tick_q,
  output logic [15:0] tick_ctrl_q
);

  klsor_pkg::klsor_state_t s_q;
  klsor_pkg::klsor_state_t s_d;
  logic key_open;

  //////////////////////////////////////////////////////////////////////////
  // next state
  assign key_open = (s_q.key == klsor_pkg::UNLOCK_VALUE);

  always_comb
  begin
    s_d = s_q;
    // two-stage synchronisers for the analog and foreign signals
    s_d.cmp_s1 = cmp_raw;
    s_d.cmp_s2 = s_q.cmp_s1;
    s_d.st_s1 = reg_raw_state;
    s_d.st_s2 = s_q.st_s1;
    s_d.lock_s1 = lock_raw;
    s_d.lock_s2 = s_q.lock_s1;
    s_d.alarm_s1 = alarm_raw;
    s_d.alarm_s2 = s_q.alarm_s1;

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        klsor_pkg::ADDR_UNLOCK_KEY: s_d.key = reg_wdata;
        klsor_pkg::ADDR_TICK_CTRL:
        begin
          if (key_open)
            s_d.tick_ctrl = reg_wdata & klsor_pkg::TICK_CTRL_WMASK;
        end
        klsor_pkg::ADDR_SIGNAL_FORCE:
          s_d.force_val = reg_wdata & klsor_pkg::FORCE_WMASK;
        default: s_d.key = s_q.key; // other addresses ignored
      endcase
    end

    // raw regulator state, zeroed by the power state machine
    s_d.raw_state = s_q.st_s2 & klsor_pkg::RAW_STATE_MASK;
    if (sm_clear)
    begin
      s_d.key = klsor_pkg::KEY_RESET;
      s_d.tick_ctrl = klsor_pkg::TICK_CTRL_RESET;
      s_d.raw_state = klsor_pkg::RAW_STATE_RESET;
    end

    // 16 kHz tick divider
    if (s_q.div == klsor_pkg::TICK16K_LAST)
    begin
      s_d.div = klsor_pkg::DIV_RESET;
      s_d.pulse16k = 1'b1;
    end
    else
    begin
      s_d.div = s_q.div + 11'h001;
      s_d.pulse16k = 1'b0;
    end

    // debounce inputs: forced or raw comparators
    if (analog_force_enable)
      s_d.deb_in = s_q.force_val & klsor_pkg::CMP_MASK;
    else
      s_d.deb_in = s_q.cmp_s2 & klsor_pkg::CMP_MASK;

    s_d.lock_ok = s_q.lock_s2 | s_q.force_val[klsor_pkg::LOCK_FORCE_BIT];
    s_d.alarm = s_q.alarm_s2 | s_q.force_val[klsor_pkg::ALARM_FORCE_BIT];
    if (s_q.force_val[klsor_pkg::TICK_FORCE_BIT])
      s_d.deb_tick = s_q.pulse16k;
    else
      s_d.deb_tick = deb_tick_normal;

    // read data, one cycle after the read strobe
    s_d.rdata = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        klsor_pkg::ADDR_UNLOCK_KEY: s_d.rdata = s_q.key;
        klsor_pkg::ADDR_TICK_CTRL: s_d.rdata = s_q.tick_ctrl;
        klsor_pkg::ADDR_SIGNAL_FORCE:
          s_d.rdata = (s_q.cmp_s2 & klsor_pkg::CMP_MASK)
            | (s_q.force_val & ~klsor_pkg::CMP_MASK);
        klsor_pkg::ADDR_REG_RAW_STATE: s_d.rdata = s_q.raw_state;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.key <= klsor_pkg::KEY_RESET;
      s_q.tick_ctrl <= klsor_pkg::TICK_CTRL_RESET;
      s_q.force_val <= klsor_pkg::FORCE_RESET;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flops
  assign reg_rdata_q = s_q.rdata;
  assign deb_in_q = s_q.deb_in;
  assign lock_ok_q = s_q.lock_ok;
  assign alarm_q = s_q.alarm;
  assign deb_tick_q = s_q.deb_tick;
  assign tick_ctrl_q = s_q.tick_ctrl;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_LOCKED_WRITE: assert property (
    reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL && !key_open
      && !sm_clear |=> s_q.tick_ctrl == $past(s_q.tick_ctrl))
    else $error("tick control changed while locked");
  AST_UNLOCKED_WRITE: assert property (
    reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL && key_open && !sm_clear
      |=> s_q.tick_ctrl == ($past(reg_wdata) & klsor_pkg::TICK_CTRL_WMASK))
    else $error("unlocked tick control write lost");
  AST_KEY_CLEAR: assert property (
    sm_clear |=> s_q.key == klsor_pkg::KEY_RESET && !key_open)
    else $error("key not cleared");
  AST_STATUS_CLEAR: assert property (
    sm_clear |=> s_q.raw_state == 16'h0000)
    else $error("raw state not cleared");
  AST_FORCE_READ_RAW: assert property (
    reg_rd && reg_addr == klsor_pkg::ADDR_SIGNAL_FORCE
      |=> (reg_rdata_q & klsor_pkg::CMP_MASK)
        == ($past(s_q.cmp_s2) & klsor_pkg::CMP_MASK))
    else $error("force read not raw");
  AST_DEB_FORCED: assert property (
    analog_force_enable
      |=> deb_in_q == ($past(s_q.force_val) & klsor_pkg::CMP_MASK))
    else $error("debounce input not forced");
  AST_DEB_RAW: assert property (
    !analog_force_enable ##1 !analog_force_enable
      |-> deb_in_q == ($past(s_q.cmp_s2) & klsor_pkg::CMP_MASK))
    else $error("debounce input not raw");
  AST_LOCK_FORCE: assert property (
    s_q.force_val[klsor_pkg::LOCK_FORCE_BIT] |=> lock_ok_q)
    else $error("lock not forced");
  AST_ALARM_FORCE: assert property (
    s_q.force_val[klsor_pkg::ALARM_FORCE_BIT] |=> alarm_q)
    else $error("alarm not forced");
  AST_TICK_FORCE: assert property (
    s_q.force_val[klsor_pkg::TICK_FORCE_BIT]
      |=> deb_tick_q == $past(s_q.pulse16k))
    else $error("debounce tick not 16 kHz");
  AST_LOCK_NORMAL: assert property (
    !s_q.force_val[klsor_pkg::LOCK_FORCE_BIT]
      |=> lock_ok_q == $past(s_q.lock_s2))
    else $error("lock not following raw flag");
  AST_ALARM_NORMAL: assert property (
    !s_q.force_val[klsor_pkg::ALARM_FORCE_BIT]
      |=> alarm_q == $past(s_q.alarm_s2))
    else $error("alarm not following normal source");
  AST_TICK_NORMAL: assert property (
    !s_q.force_val[klsor_pkg::TICK_FORCE_BIT]
      |=> deb_tick_q == $past(deb_tick_normal))
    else $error("debounce tick not normal");
  AST_KEY_WRITE: assert property (
    reg_wr && reg_addr == klsor_pkg::ADDR_UNLOCK_KEY && !sm_clear
      |=> s_q.key == $past(reg_wdata))
    else $error("key write lost");
  AST_CLEAR_WINS: assert property (
    sm_clear && reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL
      |=> s_q.tick_ctrl == klsor_pkg::TICK_CTRL_RESET)
    else $error("tick control write beat the clear");
  AST_RAW_STATE: assert property (
    !sm_clear
      |=> s_q.raw_state == ($past(s_q.st_s2) & klsor_pkg::RAW_STATE_MASK))
    else $error("raw state not tracking inputs");

  COV_UNLOCKED_WRITE: cover property (
    reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL && key_open);
  COV_ANALOG_FORCE: cover property (
    analog_force_enable && s_q.force_val[0]);
  COV_TICK_FORCE: cover property (
    s_q.force_val[klsor_pkg::TICK_FORCE_BIT] && deb_tick_q);
  COV_LOCKED_WRITE: cover property (
    reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL && !key_open);
  COV_CLEAR_WITH_WRITE: cover property (
    sm_clear && reg_wr && reg_addr == klsor_pkg::ADDR_TICK_CTRL);

endmodule // klsor_regs

// ---- hdl/klsor_pkg.sv ----
// constants and state type for the key lock and signal override registers
package klsor_pkg;

  // register addresses on the internal register port
  localparam logic [7:0] ADDR_TICK_CTRL = 8'hda;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hdb;
  localparam logic [7:0] ADDR_SIGNAL_FORCE = 8'he0;
  localparam logic [7:0] ADDR_REG_RAW_STATE = 8'he1;

  // unlock value and reset values
  localparam logic [15:0] UNLOCK_VALUE = 16'h0013;
  localparam logic [15:0] KEY_RESET = 16'h0000;
  localparam logic [15:0] TICK_CTRL_RESET = 16'h1000;
  localparam logic [15:0] FORCE_RESET = 16'h0000;
  localparam logic [15:0] RAW_STATE_RESET = 16'h0000;

  // field layouts
  localparam logic [15:0] TICK_CTRL_WMASK = 16'hb3ff;
  localparam logic [15:0] CMP_MASK = 16'h0c8f;
  localparam logic [15:0] FORCE_WMASK = 16'h0fcf;
  localparam logic [15:0] RAW_STATE_MASK = 16'h8f0f;
  localparam int LOCK_FORCE_BIT = 9;
  localparam int TICK_FORCE_BIT = 8;
  localparam int ALARM_FORCE_BIT = 6;

  // 16 kHz debounce tick from the 25 MHz core clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK16K_PERIOD_NS = 62500;
  localparam int TICK16K_CYCLES = TICK16K_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [10:0] TICK16K_LAST = 11'(TICK16K_CYCLES - 1);
  localparam logic [10:0] DIV_RESET = 11'h000;

  // complete register state of the block
  typedef struct packed {
    logic [15:0] key;
    logic [15:0] tick_ctrl;
    logic [15:0] force_val;
    logic [15:0] raw_state;
    logic [15:0] cmp_s1;
    logic [15:0] cmp_s2;
    logic [15:0] st_s1;
    logic [15:0] st_s2;
    logic lock_s1;
    logic lock_s2;
    logic alarm_s1;
    logic alarm_s2;
    logic [10:0] div;
    logic pulse16k;
    logic [15:0] deb_in;
    logic lock_ok;
    logic alarm;
    logic deb_tick;
    logic [15:0] rdata;
  } klsor_state_t;

endpackage

// ---- test/klsor_regs_test.sv ----
// self-checking testbench for the key lock and signal override registers
`timescale 1ns/1ps
module klsor_regs_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sm_clear = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic analog_force_enable = 1'b0;
  logic [15:0] cmp_raw = 16'h0000;
  logic [15:0] reg_raw_state = 16'h0000;
  logic lock_raw = 1'b0;
  logic alarm_raw = 1'b0;
  logic deb_tick_normal = 1'b0;
  logic [15:0] reg_rdata_q, deb_in_q, tick_ctrl_q;
  logic lock_ok_q, alarm_q, deb_tick_q;
  int error_cnt = 0;
  int n_compared = 0;
  int n;

  klsor_regs u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .sm_clear(sm_clear), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .analog_force_enable(analog_force_enable), .cmp_raw(cmp_raw),
    .reg_raw_state(reg_raw_state), .lock_raw(lock_raw),
    .alarm_raw(alarm_raw), .deb_tick_normal(deb_tick_normal),
    .deb_in_q(deb_in_q), .lock_ok_q(lock_ok_q),
    .alarm_q(alarm_q), .deb_tick_q(deb_tick_q), .tick_ctrl_q(tick_ctrl_q));

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  // compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, driven on the falling edge
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask

  // read strobe; data stands the cycle after the taking edge
  task rd(input logic [7:0] a, input logic [15:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata_q, exp);
    @(negedge core_clk);
  endtask

  // settle two-flop synchronisers
  task idle(input int c);
    repeat (c) @(negedge core_clk);
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    idle(12);
    arst_n = 1'b1;
    idle(2);
    rd(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0000);
    rd(klsor_pkg::ADDR_TICK_CTRL, 16'h1000);
    rd(klsor_pkg::ADDR_SIGNAL_FORCE, 16'h0000);
    rd(8'h55, 16'h0000);
    $display("test reset done");
    // locked, opened, wrong key locks again
    wr(klsor_pkg::ADDR_TICK_CTRL, 16'hffff);
    chk(tick_ctrl_q, 16'h1000);
    wr(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0013);
    rd(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0013);
    wr(klsor_pkg::ADDR_TICK_CTRL, 16'hffff);
    chk(tick_ctrl_q, 16'hb3ff);
    wr(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0012);
    wr(klsor_pkg::ADDR_TICK_CTRL, 16'h0000);
    chk(tick_ctrl_q, 16'hb3ff);
    // state machine clear relocks
    wr(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0013);
    sm_clear = 1'b1;
    wr(klsor_pkg::ADDR_TICK_CTRL, 16'hffff);
    sm_clear = 1'b0;
    chk(tick_ctrl_q, 16'h1000);
    rd(klsor_pkg::ADDR_UNLOCK_KEY, 16'h0000);
    $display("test key done");
    // force bits and raw readback
    cmp_raw = 16'h0885;
    reg_raw_state = 16'hffff;
    wr(klsor_pkg::ADDR_SIGNAL_FORCE, 16'hffff);
    idle(5);
    chk({14'h0, lock_ok_q, alarm_q}, 16'h0003);
    rd(klsor_pkg::ADDR_SIGNAL_FORCE, 16'h0bc5);
    rd(klsor_pkg::ADDR_REG_RAW_STATE, 16'h8f0f);
    chk(deb_in_q, 16'h0885);
    analog_force_enable = 1'b1;
    idle(2);
    chk(deb_in_q, 16'h0c8f);
    wr(klsor_pkg::ADDR_SIGNAL_FORCE, 16'h0100);
    idle(2);
    chk(deb_in_q, 16'h0000);
    chk({14'h0, lock_ok_q, alarm_q}, 16'h0000);
    lock_raw = 1'b1;
    alarm_raw = 1'b1;
    idle(4);
    chk({14'h0, lock_ok_q, alarm_q}, 16'h0003);
    lock_raw = 1'b0;
    alarm_raw = 1'b0;
    $display("test force done");
    // forced 16 kHz tick spacing
    n = 0;
    while (deb_tick_q !== 1'b1 && n < 3200)
    begin
      idle(1);
      n++;
    end
    chk(16'(n < 3200), 16'h0001);
    n = 0;
    idle(1);
    while (deb_tick_q !== 1'b1 && n < 3200)
    begin
      idle(1);
      n++;
    end
    chk(16'(n + 1), 16'(klsor_pkg::TICK16K_CYCLES));
    $display("test tick done");
    // mid-run reset clears the force bits, normal tick follows
    arst_n = 1'b0;
    idle(2);
    arst_n = 1'b1;
    idle(2);
    rd(klsor_pkg::ADDR_SIGNAL_FORCE, 16'h0885);
    deb_tick_normal = 1'b1;
    idle(1);
    chk({15'h0, deb_tick_q}, 16'h0001);
    deb_tick_normal = 1'b0;
    idle(1);
    chk({15'h0, deb_tick_q}, 16'h0000);
    $display("test second reset done");
    print_verdict();
  end
endmodule // klsor_regs_test
